// ---- hw/scpl_regs.svh ----
// constants of the serial command-line port
`ifndef SCPL_REGS_SVH
`define SCPL_REGS_SVH
`define SCPL_CLK_HZ 200000000
`define SCPL_BAUD 9600
`define SCPL_OVERSAMPLE 16
`define SCPL_DATA_BITS 8
`define SCPL_STOP_BITS 1
`define SCPL_ECHO_RST 1'b1
`define SCPL_FLOW_RST 1'b0
`define SCPL_LINE_DEPTH 128
`define SCPL_TXQ_DEPTH 16
`define SCPL_SMP_LO 4'h7
`define SCPL_SMP_HI 4'h9
`define SCPL_TK_LAST 4'hF
`define SCPL_CH_BS 8'h08
`define SCPL_CH_LF 8'h0A
`define SCPL_CH_CR 8'h0D
`define SCPL_CH_XON 8'h11
`define SCPL_CH_XOFF 8'h13
`define SCPL_CH_NAK 8'h15
`define SCPL_CH_CAN 8'h18
`define SCPL_CH_ESC 8'h1B
`define SCPL_CH_CTRL_MAX 8'h1F
`define SCPL_CH_SP 8'h20
`define SCPL_CH_BANG 8'h21
`define SCPL_QERR_CODE 16'hFE70
`endif

// ---- hw/scpl_pkg.sv ----
// types of the serial command-line port
package scpl_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} scpl_rx_t;
    typedef enum logic {TX_IDLE, TX_SEND} scpl_tx_t;
    typedef struct packed {
        logic echo;
        logic flow;
    } scpl_cfg_t;
    typedef struct packed {
        logic valid;
        logic [7:0] len;
    } scpl_line_t;
endpackage

// ---- hw/scpl_port.sv ----
// serial command-line port: uart, line buffer, echo and flow control
// Overview of operation
// - reset gives 9600 baud 8N1, echo on, flow control off
// - carriage return or line feed hands the buffered line to the parser
// - escape empties the line buffer and sends CR LF
// - backspace removes the last buffered character, never a terminator
// - backspace echoes as backspace, space, backspace
// - other control codes 00 to 1F are ignored
// - after the parser finishes a line, send CR LF
// - with flow control on, XON re-enables the transmitter
// - with flow control on, XOFF halts the transmitter
// - cancel clears receive and transmit queues and pointers
// - XOFF posts a queue loss error, code -400
// - with flow control on, XON drains pending transmit data then sends an exclamation mark
// - with echo on, every received non-control character is sent back
// - CR LF or LF CR back to back gives one response only
// - non-control characters go back over the same port
// - flow on: terminator answered XOFF CR with echo, else XOFF
// - echo queue overflow sends NAK and posts a queue error
`include "scpl_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module scpl_port #(
    parameter int CLK_HZ = `SCPL_CLK_HZ,
    parameter int BAUD = `SCPL_BAUD,
    parameter int LINE_DEPTH = `SCPL_LINE_DEPTH,
    parameter int TXQ_DEPTH = `SCPL_TXQ_DEPTH
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic rxd,
    output logic txd,
    input wire logic cfgWr,
    input wire scpl_pkg::scpl_cfg_t cfgIn,
    output scpl_pkg::scpl_cfg_t cfg,
    output scpl_pkg::scpl_line_t line,
    input wire logic [7:0] lineRdAddr,
    output logic [7:0] lineRdData,
    input wire logic parseDone,
    input wire logic respValid,
    input wire logic [7:0] respData,
    output logic respReady,
    output logic queueErr,
    output logic [15:0] queueErrCode
);
    import scpl_pkg::*;

    localparam int DIV16 = (CLK_HZ + BAUD * `SCPL_OVERSAMPLE / 2) /
        (BAUD * `SCPL_OVERSAMPLE);
    localparam int PW = $clog2(DIV16 + 1);
    localparam int AW = $clog2(LINE_DEPTH);
    localparam int QA = $clog2(TXQ_DEPTH);
    localparam int QW = QA + 1;

    if (DIV16 < 2 || LINE_DEPTH < 2 || LINE_DEPTH > 255 ||
        TXQ_DEPTH < 4 || (1 << QA) != TXQ_DEPTH) begin : g_chk
        $error("scpl_port: unsupported parameter values");
    end

    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
    endfunction

    // ---------------- baud tick and receiver
    logic [PW-1:0] preCnt_q;
    logic tick_q;
    logic [2:0] rxSync_q;
    logic rxIn_q;
    scpl_rx_t rxSt_q;
    logic [3:0] rxTk_q;
    logic [2:0] rxSmp_q;
    logic [2:0] rxBit_q;
    logic [7:0] rxSh_q;
    logic rxValid_q;
    logic [7:0] rxData_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            preCnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (preCnt_q == PW'(DIV16 - 1));
            preCnt_q <= (preCnt_q == PW'(DIV16 - 1)) ? '0 :
                PW'(preCnt_q + 1'b1);
        end
    end

    // a change counts only when stages two and three agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxSync_q <= 3'h7;
            rxIn_q <= 1'b1;
        end else begin
            rxSync_q <= {rxSync_q[1:0], rxd};
            if (rxSync_q[1] == rxSync_q[2])
                rxIn_q <= rxSync_q[2];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxSt_q <= RX_IDLE;
            rxTk_q <= '0;
            rxSmp_q <= '0;
            rxBit_q <= '0;
            rxSh_q <= '0;
        end else if (tick_q) begin
            unique case (rxSt_q)
                RX_IDLE: begin
                    rxTk_q <= '0;
                    rxBit_q <= '0;
                    if (!rxIn_q)
                        rxSt_q <= RX_START;
                end
                RX_START, RX_DATA, RX_STOP: begin
                    rxTk_q <= rxTk_q + 4'h1;
                    if (rxTk_q >= `SCPL_SMP_LO && rxTk_q <= `SCPL_SMP_HI)
                        rxSmp_q <= {rxSmp_q[1:0], rxIn_q};
                    if (rxTk_q == `SCPL_TK_LAST) begin
                        if (rxSt_q == RX_START) begin
                            // glitch shorter than half a bit is rejected
                            rxSt_q <= maj3(rxSmp_q) ? RX_IDLE : RX_DATA;
                        end else if (rxSt_q == RX_DATA) begin
                            rxSh_q <= {maj3(rxSmp_q), rxSh_q[7:1]};
                            rxBit_q <= rxBit_q + 3'h1;
                            if (rxBit_q == 3'(`SCPL_DATA_BITS - 1))
                                rxSt_q <= RX_STOP;
                        end else begin
                            rxSt_q <= RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // bad stop bit drops the character silently
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxValid_q <= 1'b0;
            rxData_q <= '0;
        end else begin
            rxValid_q <= tick_q && rxSt_q == RX_STOP &&
                rxTk_q == `SCPL_TK_LAST && maj3(rxSmp_q);
            if (tick_q && rxSt_q == RX_STOP && rxTk_q == `SCPL_TK_LAST)
                rxData_q <= rxSh_q;
        end
    end

    // ---------------- character decode
    scpl_cfg_t cfg_q;
    logic halt_q;
    logic bangPend_q;
    logic nakPend_q;
    logic donePend_q;
    logic [7:0] prevTerm_q;
    logic [23:0] seq_q;
    logic [1:0] seqCnt_q;
    logic [7:0] wLen_q;
    logic [QW-1:0] qCnt_q;
    scpl_tx_t txSt_q;

    logic isTerm, isPair, isCan, isXon, isXoff, isPrint;
    logic evLoad, doStore, doDel, doHand, doClr;
    logic [23:0] evSeq;
    logic [1:0] evCnt;
    logic full, txLoad, pushSeq, pushNak, pushBang, pushEn;
    wire logic [7:0] c = rxData_q;

    always_comb begin
        isTerm = rxValid_q && (c == `SCPL_CH_CR || c == `SCPL_CH_LF);
        isPair = isTerm && prevTerm_q != 8'h00 && prevTerm_q != c;
        isCan = rxValid_q && c == `SCPL_CH_CAN;
        isXon = rxValid_q && c == `SCPL_CH_XON;
        isXoff = rxValid_q && c == `SCPL_CH_XOFF;
        isPrint = rxValid_q && c > `SCPL_CH_CTRL_MAX;
        evLoad = 1'b0;
        evSeq = '0;
        evCnt = '0;
        doStore = 1'b0;
        doDel = 1'b0;
        doHand = 1'b0;
        doClr = 1'b0;
        if (isTerm && !isPair) begin
            doHand = 1'b1;
            evLoad = 1'b1;
            if (cfg_q.flow) begin
                evSeq = {8'h00, `SCPL_CH_CR, `SCPL_CH_XOFF};
                evCnt = cfg_q.echo ? 2'd2 : 2'd1;
            end else begin
                evSeq = {16'h0000, c};
                evCnt = cfg_q.echo ? 2'd1 : 2'd0;
            end
        end else if (rxValid_q && c == `SCPL_CH_ESC) begin
            // resync clears line, replies CR LF
            doClr = 1'b1;
            evLoad = 1'b1;
            evSeq = {8'h00, `SCPL_CH_LF, `SCPL_CH_CR};
            evCnt = 2'd3 - 2'd1;
        end else if (rxValid_q && c == `SCPL_CH_BS) begin
            // terminators never sit in the buffer
            doDel = (wLen_q != 8'h00);
            evLoad = cfg_q.echo;
            evSeq = {`SCPL_CH_BS, `SCPL_CH_SP, `SCPL_CH_BS};
            evCnt = 2'd3;
        end else if (isPrint) begin
            doStore = (wLen_q < 8'(LINE_DEPTH));
            evLoad = cfg_q.echo;
            evSeq = {16'h0000, c};
            evCnt = 2'd1;
        end
        // any other control code falls through unused
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            cfg_q <= '{echo: `SCPL_ECHO_RST, flow: `SCPL_FLOW_RST};
        else if (cfgWr)
            cfg_q <= cfgIn;
    end

    // remembers first terminator of a pair
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            prevTerm_q <= 8'h00;
        else if (rxValid_q)
            prevTerm_q <= (isTerm && !isPair) ? c : 8'h00;
    end

    // ---------------- line buffer
    logic [7:0] lineMem [LINE_DEPTH];
    scpl_line_t line_q;
    logic [7:0] lineRd_q;

    always_ff @(posedge clk) begin
        if (doStore)
            lineMem[wLen_q[AW-1:0]] <= c;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wLen_q <= 8'h00;
            line_q <= '0;
            lineRd_q <= 8'h00;
        end else begin
            line_q.valid <= doHand;
            lineRd_q <= lineMem[lineRdAddr[AW-1:0]];
            if (doHand)
                line_q.len <= wLen_q;
            if (doHand || doClr || isCan)
                wLen_q <= 8'h00;
            else if (doDel)
                wLen_q <= wLen_q - 8'h01;
            else if (doStore)
                wLen_q <= wLen_q + 8'h01;
        end
    end

    // ---------------- flow control
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            halt_q <= 1'b0;
            bangPend_q <= 1'b0;
        end else begin
            if (isXoff && cfg_q.flow)
                halt_q <= 1'b1;
            else if (isXon && cfg_q.flow)
                halt_q <= 1'b0;
            if (isXon && cfg_q.flow)
                bangPend_q <= 1'b1;
            else if (pushBang || isCan)
                bangPend_q <= 1'b0;
        end
    end

    // ---------------- transmit queue
    logic [7:0] txq [TXQ_DEPTH];
    logic [QA-1:0] qWr_q, qRd_q;
    logic respReady_q;
    logic [7:0] pushData;

    always_comb begin
        full = (qCnt_q == QW'(TXQ_DEPTH));
        txLoad = txSt_q == TX_IDLE && qCnt_q != '0 && !halt_q;
        pushSeq = seqCnt_q != 2'd0 && !full && !(respValid && respReady_q);
        pushNak = nakPend_q && seqCnt_q == 2'd0 && !full &&
            !(respValid && respReady_q);
        // bang only once queue and line are idle
        pushBang = bangPend_q && qCnt_q == '0 && txSt_q == TX_IDLE &&
            !halt_q && seqCnt_q == 2'd0 && !nakPend_q && !respValid;
        pushEn = (respValid && respReady_q) || pushSeq || pushNak ||
            pushBang;
        pushData = (respValid && respReady_q) ? respData :
            pushSeq ? seq_q[7:0] : pushNak ? `SCPL_CH_NAK :
            `SCPL_CH_BANG;
    end

    always_ff @(posedge clk) begin
        if (pushEn)
            txq[qWr_q] <= pushData;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            qWr_q <= '0;
            qRd_q <= '0;
            qCnt_q <= '0;
            respReady_q <= 1'b0;
        end else if (isCan) begin
            qWr_q <= '0;
            qRd_q <= '0;
            qCnt_q <= '0;
            respReady_q <= 1'b0;
        end else begin
            // margin of two covers the registered ready
            respReady_q <= qCnt_q < QW'(TXQ_DEPTH - 2);
            if (pushEn)
                qWr_q <= qWr_q + 1'b1;
            if (txLoad)
                qRd_q <= qRd_q + 1'b1;
            qCnt_q <= QW'(qCnt_q + QW'(pushEn) - QW'(txLoad));
        end
    end

    // seq holds up to three reply bytes, oldest in the low byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            seq_q <= '0;
            seqCnt_q <= 2'd0;
            nakPend_q <= 1'b0;
            donePend_q <= 1'b0;
        end else if (isCan) begin
            seqCnt_q <= 2'd0;
            nakPend_q <= 1'b0;
            donePend_q <= 1'b0;
        end else begin
            if (parseDone)
                donePend_q <= 1'b1;
            if (evLoad && evCnt != 2'd0) begin
                seq_q <= evSeq;
                seqCnt_q <= evCnt;
            end else if (donePend_q && seqCnt_q == 2'd0) begin
                // CR LF once the line is dispatched
                seq_q <= {8'h00, `SCPL_CH_LF, `SCPL_CH_CR};
                seqCnt_q <= 2'd2;
                // a done in this same cycle stays pending
                donePend_q <= parseDone;
            end else if (seqCnt_q != 2'd0 && full) begin
                // overflow drops the reply and flags NAK
                seqCnt_q <= 2'd0;
                nakPend_q <= 1'b1;
            end else if (pushSeq) begin
                seq_q <= {8'h00, seq_q[23:8]};
                seqCnt_q <= seqCnt_q - 2'd1;
            end
            if (pushNak)
                nakPend_q <= 1'b0;
        end
    end

    // queue loss error on XOFF or overflow
    logic queueErr_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            queueErr_q <= 1'b0;
        else
            queueErr_q <= isXoff || pushNak;
    end

    // ---------------- transmitter
    logic [9:0] txSh_q;
    logic [3:0] txTk_q;
    logic [3:0] txBit_q;
    logic txd_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            txSt_q <= TX_IDLE;
            txSh_q <= '1;
            txTk_q <= '0;
            txBit_q <= '0;
            txd_q <= 1'b1;
        end else begin
            unique case (txSt_q)
                TX_IDLE: begin
                    if (txLoad) begin
                        txSh_q <= {1'b1, txq[qRd_q], 1'b0};
                        txd_q <= 1'b0;
                        txTk_q <= '0;
                        txBit_q <= '0;
                        txSt_q <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (tick_q) begin
                        txTk_q <= txTk_q + 4'h1;
                        if (txTk_q == `SCPL_TK_LAST) begin
                            txBit_q <= txBit_q + 4'h1;
                            txSh_q <= {1'b1, txSh_q[9:1]};
                            txd_q <= txSh_q[1];
                            if (txBit_q == 4'd9) begin
                                txd_q <= 1'b1;
                                txSt_q <= TX_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    assign txd = txd_q;
    assign cfg = cfg_q;
    assign line = line_q;
    assign lineRdData = lineRd_q;
    assign respReady = respReady_q;
    assign queueErr = queueErr_q;
    assign queueErrCode = `SCPL_QERR_CODE;

    // ---------------- checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_term_hand: assert property (
        isTerm && !isPair |=> line_q.valid)
        else $error("terminator not handed over");
    a_esc_clear: assert property (
        rxValid_q && c == `SCPL_CH_ESC |=> wLen_q == 8'h00 &&
        seqCnt_q == 2'd2 && seq_q[7:0] == `SCPL_CH_CR)
        else $error("escape did not clear and reply");
    a_bs_remove: assert property (
        doDel |=> wLen_q == $past(wLen_q) - 8'h01)
        else $error("backspace removal wrong");
    a_bs_echo: assert property (
        rxValid_q && c == `SCPL_CH_BS && cfg_q.echo |=> seqCnt_q == 2'd3)
        else $error("backspace echo wrong");
    a_ctrl_drop: assert property (
        rxValid_q && c <= `SCPL_CH_CTRL_MAX && !(c inside {`SCPL_CH_BS,
        `SCPL_CH_LF, `SCPL_CH_CR, `SCPL_CH_XON, `SCPL_CH_XOFF,
        `SCPL_CH_CAN, `SCPL_CH_ESC}) && seqCnt_q == 2'd0 && !donePend_q
        |=> seqCnt_q == 2'd0 && $stable(wLen_q))
        else $error("ignored control acted on");
    a_xoff_err: assert property (
        isXoff && cfg_q.flow |=> halt_q && queueErr_q)
        else $error("xoff not handled");
    a_xon_go: assert property (
        isXon && cfg_q.flow |=> !halt_q && bangPend_q)
        else $error("xon not handled");
    a_can_clear: assert property (
        isCan |=> qCnt_q == '0 && wLen_q == 8'h00 && seqCnt_q == 2'd0)
        else $error("cancel did not clear");
    a_halt_hold: assert property (
        halt_q && txSt_q == TX_IDLE |=> txSt_q == TX_IDLE)
        else $error("sent while halted");
    a_pair_once: assert property (
        isPair && seqCnt_q == 2'd0 && !donePend_q |=> seqCnt_q == 2'd0 &&
        !line_q.valid)
        else $error("second terminator answered");
    a_nak_err: assert property (
        pushNak |=> queueErr_q)
        else $error("nak without error");
    a_rx_frame: assert property (
        rxValid_q |-> $past(rxSt_q) == RX_STOP)
        else $error("char outside stop bit");

    c_echo: cover property (isPrint && cfg_q.echo ##1 pushSeq);
    c_flow: cover property (isXoff && cfg_q.flow ##[1:1000] isXon);
    c_bang: cover property (pushBang);
    c_line: cover property (line_q.valid && line_q.len != 8'h00);
endmodule
`default_nettype wire

// ---- testbench/scpl_host.sv ----
// host terminal model: serial sender and echo receiver
`timescale 1ns/10ps
`default_nettype none
module scpl_host #(
    parameter int BITCLK = 64
) (
    input wire logic clk,
    output logic rxd,
    input wire logic txd
);
    logic [7:0] rxq[$];
    logic [7:0] d;
    logic heldOff = 1'b0;
    int waitOut = 0;

    initial rxd = 1'b1;

    task automatic sendChar(input logic [7:0] c);
        int i;
        i = 0;
        while (heldOff && c > 8'h1F && i < 20000) begin
            @(negedge clk);
            i++;
        end
        if (i >= 20000) begin
            waitOut++;
        end
        @(negedge clk);
        rxd = 1'b0;
        repeat (BITCLK) @(negedge clk);
        for (int b = 0; b < 8; b++) begin
            rxd = c[b];
            repeat (BITCLK) @(negedge clk);
        end
        rxd = 1'b1;
        repeat (BITCLK) @(negedge clk);
    endtask

    // every returned byte is queued for the bench to verify
    always begin
        @(posedge clk iff txd === 1'b0);
        repeat (BITCLK / 2) @(posedge clk);
        if (txd === 1'b0) begin
            for (int b = 0; b < 8; b++) begin
                repeat (BITCLK) @(posedge clk);
                d[b] = txd;
            end
            repeat (BITCLK) @(posedge clk);
            rxq.push_back(d);
            if (d == 8'h13) begin
                heldOff = 1'b1;
            end else if (d == 8'h11) begin
                heldOff = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/scpl_port_bench.sv ----
// self-checking bench of the serial command-line port
`timescale 1ns/10ps
`default_nettype none
module scpl_port_bench;
    import scpl_pkg::*;
    localparam logic [7:0] CR = 8'h0D, LF = 8'h0A, BS = 8'h08, SP = 8'h20;
    localparam logic [7:0] ESC = 8'h1B, XON = 8'h11, XOFF = 8'h13;
    localparam logic [7:0] CAN = 8'h18, BANG = 8'h21;
    logic clk = 1'b0, resetn = 1'b0, rxd, txd, cfgWr = 1'b0;
    logic parseDone = 1'b0, respValid = 1'b0, respReady, queueErr;
    logic [7:0] lineRdAddr = 8'h00, lineRdData, respData = 8'h00;
    logic [15:0] queueErrCode;
    scpl_cfg_t cfgIn = 2'b10, cfg;
    scpl_line_t line;
    int n_fail = 0, n_checks = 0, lineCnt = 0, errCnt = 0, c0, e0;
    logic [7:0] lastLen = 8'h00;
    logic [7:0] txt[16];
    logic [7:0] ctlCodes[4] = '{8'h00, 8'h07, 8'h0C, 8'h1F};
    logic [31:0] seed = 32'hB4CB;

    always #2.5 clk = ~clk;

    // divider of 4 keeps frames short
    scpl_port #(.CLK_HZ(614400), .BAUD(9600)) scpl_port_inst (
        .clk(clk), .resetn(resetn), .rxd(rxd), .txd(txd), .cfgWr(cfgWr),
        .cfgIn(cfgIn), .cfg(cfg), .line(line), .lineRdAddr(lineRdAddr),
        .lineRdData(lineRdData), .parseDone(parseDone),
        .respValid(respValid), .respData(respData), .respReady(respReady),
        .queueErr(queueErr), .queueErrCode(queueErrCode));
    scpl_host #(.BITCLK(64)) scpl_host_inst (
        .clk(clk), .rxd(rxd), .txd(txd));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic conclude;
        if (n_fail == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmpVal(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmpTx(input logic [7:0] exp);
        int i;
        i = 0;
        while (scpl_host_inst.rxq.size() == 0 && i < 3000) begin
            @(negedge clk);
            i++;
        end
        if (scpl_host_inst.rxq.size() == 0) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, 8'h00, exp);
            conclude();
        end else begin
            cmpVal({8'h00, scpl_host_inst.rxq.pop_front()}, {8'h00, exp});
        end
    endtask

    task automatic expQuiet(input int cycles);
        repeat (cycles) @(negedge clk);
        cmpVal(16'(scpl_host_inst.rxq.size()), 16'h0000);
    endtask

    task automatic typeText(input int n);
        for (int k = 0; k < n; k++) begin
            seed = lfsr(seed);
            txt[k] = 8'h41 + {3'h0, seed[4:0]};
            scpl_host_inst.sendChar(txt[k]);
        end
    endtask

    task automatic echoText(input int n);
        for (int k = 0; k < n; k++) begin
            cmpTx(txt[k]);
        end
    endtask

    task automatic termLine(input logic [7:0] len);
        c0 = lineCnt;
        scpl_host_inst.sendChar(CR);
        repeat (40) @(negedge clk);
        cmpVal(16'(lineCnt - c0), 16'h0001);
        cmpVal({8'h00, lastLen}, {8'h00, len});
        for (int k = 0; k < len; k++) begin
            lineRdAddr = 8'(k);
            @(negedge clk);
            cmpVal({8'h00, lineRdData}, {8'h00, txt[k]});
        end
    endtask

    task automatic pushResp(input logic [7:0] c);
        int i;
        i = 0;
        while (respReady !== 1'b1 && i < 3000) begin
            @(negedge clk);
            i++;
        end
        if (respReady !== 1'b1) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, respReady, 1'b1);
            conclude();
        end
        respValid = 1'b1;
        respData = c;
        @(negedge clk);
        respValid = 1'b0;
        @(negedge clk);
    endtask

    always @(posedge clk) begin
        if (line.valid === 1'b1) begin
            lineCnt++;
            lastLen = line.len;
        end
        if (queueErr === 1'b1) begin
            errCnt++;
            cmpVal(queueErrCode, 16'hFE70);
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        cmpVal({14'h0, cfg}, 16'h0002);
        cmpVal({15'h0, txd}, 16'h0001);
        repeat (4) @(negedge clk);
        // random text, terminator pair, parser completion
        typeText(3);
        termLine(8'h03);
        c0 = lineCnt;
        scpl_host_inst.sendChar(LF);
        echoText(3);
        cmpTx(CR);
        expQuiet(800);
        cmpVal(16'(lineCnt - c0), 16'h0000);
        parseDone = 1'b1;
        @(negedge clk);
        parseDone = 1'b0;
        cmpTx(CR);
        cmpTx(LF);
        // erase the last character
        typeText(2);
        scpl_host_inst.sendChar(BS);
        termLine(8'h01);
        echoText(2);
        cmpTx(BS);
        cmpTx(SP);
        cmpTx(BS);
        cmpTx(CR);
        // resynchronise with escape
        typeText(1);
        scpl_host_inst.sendChar(ESC);
        termLine(8'h00);
        echoText(1);
        cmpTx(CR);
        cmpTx(LF);
        cmpTx(CR);
        // unused control codes are dropped
        foreach (ctlCodes[k]) begin
            scpl_host_inst.sendChar(ctlCodes[k]);
        end
        expQuiet(400);
        typeText(1);
        termLine(8'h01);
        echoText(1);
        cmpTx(CR);
        // pause request without flow control still logs a loss
        e0 = errCnt;
        scpl_host_inst.sendChar(XOFF);
        repeat (20) @(negedge clk);
        cmpVal(16'(errCnt - e0), 16'h0001);
        // flow control on
        cfgIn = 2'b11;
        cfgWr = 1'b1;
        @(negedge clk);
        cfgWr = 1'b0;
        @(negedge clk);
        cmpVal({14'h0, cfg}, 16'h0003);
        termLine(8'h00);
        cmpTx(XOFF);
        cmpTx(CR);
        scpl_host_inst.sendChar(XOFF);
        // halt lands a few cycles after the host's stop bit
        repeat (40) @(negedge clk);
        pushResp(8'h41);
        pushResp(8'h42);
        expQuiet(1000);
        scpl_host_inst.sendChar(XON);
        cmpTx(8'h41);
        cmpTx(8'h42);
        cmpTx(BANG);
        // cancel while halted discards queued bytes
        scpl_host_inst.sendChar(XOFF);
        repeat (40) @(negedge clk);
        pushResp(8'h43);
        pushResp(8'h44);
        scpl_host_inst.sendChar(CAN);
        scpl_host_inst.sendChar(XON);
        cmpTx(BANG);
        expQuiet(1000);
        // halted queue fills, backspace echo overflows into NAK
        e0 = errCnt;
        scpl_host_inst.sendChar(XOFF);
        repeat (40) @(negedge clk);
        for (int k = 0; k < 14; k++) begin
            seed = lfsr(seed);
            txt[k] = seed[7:0];
            pushResp(txt[k]);
        end
        cmpVal({15'h0, respReady}, 16'h0000);
        scpl_host_inst.sendChar(BS);
        scpl_host_inst.sendChar(XON);
        echoText(14);
        cmpTx(BS);
        cmpTx(SP);
        cmpTx(8'h15);
        cmpTx(BANG);
        cmpVal(16'(errCnt - e0), 16'h0002);
        // flow control without echo answers a terminator with XOFF only
        cfgIn = 2'b01;
        cfgWr = 1'b1;
        @(negedge clk);
        cfgWr = 1'b0;
        termLine(8'h00);
        cmpTx(XOFF);
        expQuiet(800);
        cmpVal(16'(scpl_host_inst.waitOut), 16'h0000);
        conclude();
    end
endmodule
`default_nettype wire
